// File: logic/apg_regs.sv
// Purpose: Gain and mode registers for the eight-channel amplifier stage
// Assumes: Simple register port, read data one cycle after the read strobe
// Notes: Reserved bits read zero; unmapped reads return zero
`timescale 1ns/1ns
// Operation
// - Eight 2-bit gain codes, reset zero
// - Codes map to x1, x2, x3, x5
// - Gain factor depends on the gain code only, not on channel mode
// - Per-channel invert bits 8 to 15
// - Per-pair differential fields bits 7:0
module apg_regs
  import apg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Amplifier settings per channel
  output logic [15:0] gain_code_o,
  output logic [7:0] invert_o,
  output logic [7:0] pair_diff_o,
  output logic [23:0] gain_factor_o,
  output logic [7:0] bypass_o,
  output logic [7:0] diff_mode_o
);
  typedef struct packed {
    logic [31:0] gain;
    logic [31:0] mode;
    logic [31:0] rdata;
  } apg_rg_state_t;

  apg_rg_state_t st_r;
  apg_rg_state_t st_nxt;
  apg_mode_t mode_w [NUM_CHAN];

  // Gain code of one channel, shared by the code outputs and the decoders
  function automatic logic [1:0] gain_field(input logic [31:0] word, input int chan);
    return word[GAIN_STRIDE*chan +: 2];
  endfunction

  // Register updates and read path
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    if (wr_i && addr_i == AMP_GAIN_OFS) begin
      st_nxt.gain = wdata_i & AMP_GAIN_MASK;
    end
    if (wr_i && addr_i == AMP_MODE_OFS) begin
      st_nxt.mode = wdata_i & AMP_MODE_MASK;
    end
    if (rd_i) begin
      if (addr_i == AMP_GAIN_OFS) begin
        st_nxt.rdata = st_r.gain;
      end else if (addr_i == AMP_MODE_OFS) begin
        st_nxt.rdata = st_r.mode;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '{gain: AMP_GAIN_RST, mode: AMP_MODE_RST, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;

  // Per-channel field extraction and decode
  for (genvar n = 0; n < NUM_CHAN; n++) begin : g_chan
    assign gain_code_o[2*n +: 2] = gain_field(st_r.gain, n);
    assign invert_o[n] = st_r.mode[INV_BASE + n];
    assign pair_diff_o[n] = st_r.mode[PAIR_STRIDE*(n/2)];
    assign diff_mode_o[n] = (mode_w[n] == APG_MODE_DIFF);
    apg_chan_gain u_chan (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .gain_code_i(gain_field(st_r.gain, n)),
      .invert_i(st_r.mode[INV_BASE + n]),
      .pair_diff_i(st_r.mode[PAIR_STRIDE*(n/2) +: 2]),
      .gain_factor_o(gain_factor_o[3*n +: 3]),
      .bypass_o(bypass_o[n]),
      .invert_o(),
      .mode_o(mode_w[n])
    );
  end

  // Checks
  property p_gain_wr;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_i && addr_i == AMP_GAIN_OFS |=> st_r.gain == ($past(wdata_i) & AMP_GAIN_MASK);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");

  property p_gain_rsv;
    @(posedge clk_i) disable iff (!reset_n_i) (st_r.gain & ~AMP_GAIN_MASK) == 32'h0;
  endproperty
  a_gain_rsv: assert property (p_gain_rsv) else $error("gain reserved set");

  property p_mode_rsv;
    @(posedge clk_i) disable iff (!reset_n_i) st_r.mode[31:16] == 16'h0;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved set");

  property p_inv_wr;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_i && addr_i == AMP_MODE_OFS |=> invert_o == $past(wdata_i[15:8]);
  endproperty
  a_inv_wr: assert property (p_inv_wr) else $error("invert write lost");

  property p_x5;
    @(posedge clk_i) disable iff (!reset_n_i)
      st_r.gain[1:0] == GAIN_CODE_X5 && $stable(st_r.gain) |=> gain_factor_o[2:0] == 3'h5;
  endproperty
  a_x5: assert property (p_x5) else $error("x5 decode wrong");

  property p_x1;
    @(posedge clk_i) disable iff (!reset_n_i)
      st_r.gain[29:28] == GAIN_CODE_X1 |=> bypass_o[7];
  endproperty
  a_x1: assert property (p_x1) else $error("bypass missing");

  property p_diff;
    @(posedge clk_i) disable iff (!reset_n_i)
      st_r.mode[1:0] == 2'h1 |=> diff_mode_o[0] && diff_mode_o[1];
  endproperty
  a_diff: assert property (p_diff) else $error("pair mode wrong");

  sequence s_mode_rd;
    rd_i && addr_i == AMP_MODE_OFS && !wr_i;
  endsequence
  property p_mode_rd;
    @(posedge clk_i) disable iff (!reset_n_i) s_mode_rd |=> rdata_o == $past(st_r.mode);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");

  // Writes elsewhere leave both registers alone
  property p_gain_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == AMP_GAIN_OFS) |=> $stable(st_r.gain);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

  property p_mode_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == AMP_MODE_OFS) |=> $stable(st_r.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

  // A mode write lands whole, reserved bits dropped
  property p_mode_wr;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_i && addr_i == AMP_MODE_OFS |=> st_r.mode == ($past(wdata_i) & AMP_MODE_MASK);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

  // A gain write shows on the code outputs in the next cycle
  property p_ch7_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_i && addr_i == AMP_GAIN_OFS |=> gain_code_o[15:14] == $past(wdata_i[29:28]);
  endproperty
  a_ch7_code: assert property (p_ch7_code) else $error("top gain code wrong");

  // Read data carry the register as it stood at the strobe
  property p_gain_rd;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == AMP_GAIN_OFS |=> rdata_o == $past(st_r.gain);
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain read wrong");

  // Reads of unmapped places return zero
  property p_unmapped_rd;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i != AMP_GAIN_OFS && addr_i != AMP_MODE_OFS |=> rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  // A gain write reaches the channel decoder two edges later
  sequence s_wr_ch3_x3;
    wr_i && addr_i == AMP_GAIN_OFS && wdata_i[13:12] == GAIN_CODE_X3;
  endsequence
  sequence s_ch3_factor_x3;
    ##2 gain_factor_o[11:9] == 3'h3;
  endsequence
  property p_x3_path;
    @(posedge clk_i) disable iff (!reset_n_i) s_wr_ch3_x3 |-> s_ch3_factor_x3;
  endproperty
  a_x3_path: assert property (p_x3_path) else $error("x3 decode wrong");

  sequence s_wr_ch6_x2;
    wr_i && addr_i == AMP_GAIN_OFS && wdata_i[25:24] == GAIN_CODE_X2;
  endsequence
  sequence s_ch6_factor_x2;
    ##2 gain_factor_o[20:18] == 3'h2;
  endsequence
  property p_x2_path;
    @(posedge clk_i) disable iff (!reset_n_i) s_wr_ch6_x2 |-> s_ch6_factor_x2;
  endproperty
  a_x2_path: assert property (p_x2_path) else $error("x2 decode wrong");

  // A pair set to one turns both its channels differential two edges later
  sequence s_wr_pair_b_diff;
    wr_i && addr_i == AMP_MODE_OFS && wdata_i[3:2] == 2'h1;
  endsequence
  sequence s_pair_b_both_diff;
    ##2 diff_mode_o[2] && diff_mode_o[3];
  endsequence
  property p_pair_b_path;
    @(posedge clk_i) disable iff (!reset_n_i) s_wr_pair_b_diff |-> s_pair_b_both_diff;
  endproperty
  a_pair_b_path: assert property (p_pair_b_path) else $error("pair b mode wrong");

  // Any nonzero code leaves the bypass off
  property p_not_bypass;
    @(posedge clk_i) disable iff (!reset_n_i)
      st_r.gain[13:12] != GAIN_CODE_X1 |=> !bypass_o[3];
  endproperty
  a_not_bypass: assert property (p_not_bypass) else $error("bypass stuck on");

  // Pair values other than one stay single-ended
  property p_single;
    @(posedge clk_i) disable iff (!reset_n_i)
      st_r.mode[7:6] != 2'h1 |=> !diff_mode_o[6] && !diff_mode_o[7];
  endproperty
  a_single: assert property (p_single) else $error("pair hi mode wrong");
endmodule

// File: common/apg_pkg.sv
// Purpose: Shared constants for the amplifier gain and mode register bank
// Assumes: 32-bit register port, byte offsets, one clock at 125 MHz
// Notes: Gain register offset is not printed and is chosen here
package apg_pkg;
  // Register byte offsets
  localparam logic [7:0] AMP_MODE_OFS = 8'h3C;
  localparam logic [7:0] AMP_GAIN_OFS = 8'h38;
  // Channel count and field layout
  localparam int NUM_CHAN = 8;
  localparam int GAIN_STRIDE = 4;
  localparam int INV_BASE = 8;
  localparam int PAIR_STRIDE = 2;
  // Reset values
  localparam logic [31:0] AMP_GAIN_RST = 32'h0000_0000;
  localparam logic [31:0] AMP_MODE_RST = 32'h0000_0000;
  // Writable bit masks; all other bits are read-only zero
  localparam logic [31:0] AMP_GAIN_MASK = 32'h3333_3333;
  localparam logic [31:0] AMP_MODE_MASK = 32'h0000_FFFF;
  // Gain code encodings
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [1:0] GAIN_CODE_X3 = 2'h2;
  localparam logic [1:0] GAIN_CODE_X5 = 2'h3;
  // Amplifier mode per channel, one-hot
  typedef enum logic [1:0] {
    APG_MODE_SINGLE = 2'h1,
    APG_MODE_DIFF = 2'h2
  } apg_mode_t;
endpackage

// File: logic/apg_chan_gain.sv
// Purpose: Decodes one channel's gain code and amplifier mode
// Assumes: Inputs come from registers on the same clock
// Notes: Gain factor output is the numeric multiplier, registered
`timescale 1ns/1ns
module apg_chan_gain
  import apg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Channel configuration
  input wire logic [1:0] gain_code_i,
  input wire logic invert_i,
  input wire logic [1:0] pair_diff_i,
  // Decoded amplifier setting
  output logic [2:0] gain_factor_o,
  output logic bypass_o,
  output logic invert_o,
  output apg_mode_t mode_o
);
  typedef struct packed {
    logic [2:0] factor;
    logic bypass;
    logic invert;
    apg_mode_t mode;
  } apg_cg_state_t;

  apg_cg_state_t st_r;
  apg_cg_state_t st_nxt;

  // Code to multiplier
  function automatic logic [2:0] code_factor(input logic [1:0] code);
    unique case (code)
      GAIN_CODE_X1: code_factor = 3'h1;
      GAIN_CODE_X2: code_factor = 3'h2;
      GAIN_CODE_X3: code_factor = 3'h3;
      GAIN_CODE_X5: code_factor = 3'h5;
    endcase
  endfunction

  // Next setting
  always_comb begin
    st_nxt.factor = code_factor(gain_code_i);
    st_nxt.bypass = (gain_code_i == GAIN_CODE_X1);
    st_nxt.invert = invert_i;
    // Only value one activates differential operation
    st_nxt.mode = (pair_diff_i == 2'h1) ? APG_MODE_DIFF : APG_MODE_SINGLE;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '{factor: 3'h1, bypass: 1'b1, invert: 1'b0, mode: APG_MODE_SINGLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gain_factor_o = st_r.factor;
  assign bypass_o = st_r.bypass;
  assign invert_o = st_r.invert;
  assign mode_o = st_r.mode;
endmodule

// File: verif/apg_regs_tb_top.sv
// Purpose: Self-checking bench for the amplifier gain and mode registers
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Integer model of both registers predicts every output and read
`timescale 1ns/1ns
module apg_regs_tb_top;
  import apg_pkg::*;
  // Design ports
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] gain_code_o;
  logic [7:0] invert_o, pair_diff_o, bypass_o, diff_mode_o;
  logic [23:0] gain_factor_o;
  // Model state and counters
  int err_count = 0;
  int comparisons = 0;
  int gain_m = 0;
  int mode_m = 0;
  int rd_q[$];
  logic [31:0] r;

  apg_regs u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .gain_code_o(gain_code_o), .invert_o(invert_o), .pair_diff_o(pair_diff_o),
    .gain_factor_o(gain_factor_o), .bypass_o(bypass_o), .diff_mode_o(diff_mode_o));

  // 125 MHz clock
  initial forever #4 clk_i = ~clk_i;

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One read cycle, data checked in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(rdata_o, rd_q.pop_front());
  endtask

  // One write cycle, then every decoded output and a read back
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int c;
    int f;
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a == AMP_GAIN_OFS) gain_m = d & AMP_GAIN_MASK;
    if (a == AMP_MODE_OFS) mode_m = d & AMP_MODE_MASK;
    @(posedge clk_i);
    #1;
    for (int n = 0; n < NUM_CHAN; n++) begin
      c = (gain_m >> (4 * n)) & 3;
      f = (mode_m >> (2 * (n / 2))) & 3;
      cmp(gain_code_o[2*n +: 2], c);
      cmp(gain_factor_o[3*n +: 3], (c == 3) ? 5 : c + 1);
      cmp(bypass_o[n], c == 0);
      cmp(invert_o[n], (mode_m >> (8 + n)) & 1);
      cmp(pair_diff_o[n], f & 1);
      cmp(diff_mode_o[n], f == 1);
    end
    rd(a, (a == AMP_GAIN_OFS) ? gain_m : ((a == AMP_MODE_OFS) ? mode_m : 0));
  endtask

  // Main sequence: reset values, every code and field value, reserved bits,
  // unmapped places, random traffic, then a second reset
  initial begin
    r = $urandom(32'hC6D4);
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(AMP_GAIN_OFS, 32'h0000_0000);
    rd(AMP_MODE_OFS, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wr(AMP_GAIN_OFS, 32'h1111_1111 * k);
      wr(AMP_MODE_OFS, 32'h0000_5555 * k);
    end
    wr(AMP_GAIN_OFS, 32'hFFFF_FFFF);
    wr(AMP_MODE_OFS, 32'hFFFF_FFFF);
    wr(8'h40, 32'h0000_0000);
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      wr(r[0] ? AMP_GAIN_OFS : (r[1] ? AMP_MODE_OFS : r[9:2]), $urandom);
    end
    // Second reset, driven on the edge like every other input
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    gain_m = 0;
    mode_m = 0;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(AMP_GAIN_OFS, 32'h0000_0000);
    rd(AMP_MODE_OFS, 32'h0000_0000);
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule
